// file: isdf_top.sv
`timescale 1ns/100ps
// Function
// - Tx write or read-then-zero clears empty
// - Empty sets on load, direction, start
// - End sets at ninth rise while empty
// - Full sets on receive copy, read clears
// - No-ack sets when checked ack high
// - Stop flag for master or addressed slave
// - Arbitration lost on SDA mismatch
// - Address flag on own or general call
// - General call flag in slave receive
// - Own address in bits seven to one
// - Holding byte feeds shifter, back to back
// - Received byte copied, receive reg read-only
// - Clock duty even or forty-sixty
// - Glitch filter one or two cycles
// - Filter register upper bits read zero
// - First frame is address plus direction
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - Direction one means slave to master
// - Receiver pulls SDA low for ack
// - Master transmit drives clock and data
// - Mismatch shows another master owns bus
// - Checked no-ack halts continuous transfer
// - No-ack request from flags and enable
module isdf_top
  import isdf_pkg::*;
#(
  parameter int unsigned SCL_CYC = SCL_PERIOD_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       SCL_I,
  output logic            SCL_O,
  output logic            SCL_OE_N_O,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N_O,
  output logic            NAK_IRQ_O
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RS, ST_SB, ST_SC, ST_XFER, ST_PA, ST_PB
  } isdf_state_type;

  isdf_state_type  st_r, st_nxt;       // Master sequencer
  isdf_flags_type  fl_r, fl_nxt;       // Status flags
  isdf_events_type ev;                 // Bus conditions
  logic [7:0] fl_set, fl_clr;          // Flag set and clear terms
  logic [7:0] seen_r, seen_nxt;        // Flags read as one
  logic [6:0] own_r, own_nxt;          // Own address bits
  logic [7:0] tx_r, tx_nxt;            // Transmit holding
  logic [7:0] rx_r, rx_nxt;            // Receive holding
  logic [7:0] sh_r, sh_nxt;            // Serial shifter
  logic [7:0] rdata_r, rdata_nxt;      // Read data
  logic       duty_r, duty_nxt;        // Clock duty select
  logic       nf2_r, nf2_nxt;          // Filter range select
  logic       mst_r, mst_nxt;          // Master mode
  logic       txdir_r, txdir_nxt;      // Transmit direction
  logic       sreq_r, sreq_nxt;        // Start request
  logic       preq_r, preq_nxt;        // Stop request
  logic       irqen_r, irqen_nxt;      // No-ack request enable
  logic       ackchk_r, ackchk_nxt;    // Ack check enable
  logic       ackbr_r, ackbr_nxt;      // Received ack bit
  logic       ackbt_r, ackbt_nxt;      // Ack bit to send
  logic       busy_r, busy_nxt;        // Bus busy
  logic [3:0] bitc_r, bitc_nxt;        // Bit in frame, 8 is ack
  logic       ld_r, ld_nxt;            // Frame under way
  logic       first_r, first_nxt;      // Address frame
  logic       adr_r, adr_nxt;          // Addressed as slave
  logic       sdal_r, sdal_nxt;        // Pull SDA low
  logic       scll_r, scll_nxt;        // Pull SCL low
  logic       pscl_r, psda_r;          // Previous filtered levels
  logic       scl_f, sda_f;            // Filtered levels
  logic       tlow, ttick, tclr;       // Clock timer
  logic       mx, lp, hold, halt;      // Engine terms
  logic       rxing;                   // This byte is received
  logic [7:0] byte_in;                 // Byte completed at this rise

  // Line filters
  isdf_filter u_scl_filt (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   (SCL_I),
    .nf2_i   (nf2_r),
    .level_o (scl_f)
  );
  isdf_filter u_sda_filt (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   (SDA_I),
    .nf2_i   (nf2_r),
    .level_o (sda_f)
  );

  // Master clock phases
  isdf_scl_timer #(.PERIOD(SCL_CYC)) u_timer (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .clr_i   (tclr),
    .pause_i (hold),
    .duty_i  (duty_r),
    .scl_i   (scl_f),
    .low_o   (tlow),
    .tick_o  (ttick)
  );

  // Start, stop and clock edges on the filtered lines
  always_comb begin
    ev.start = scl_f & pscl_r & psda_r & ~sda_f;
    ev.stop  = scl_f & pscl_r & ~psda_r & sda_f;
    ev.rise  = scl_f & ~pscl_r;
    ev.fall  = ~scl_f & pscl_r;
  end

  // Next values of all control state
  always_comb begin
    st_nxt = st_r;
    fl_set = '0;
    fl_clr = '0;
    seen_nxt = seen_r;
    own_nxt = own_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    sh_nxt = sh_r;
    rdata_nxt = RST_BYTE;
    duty_nxt = duty_r;
    nf2_nxt = nf2_r;
    mst_nxt = mst_r;
    txdir_nxt = txdir_r;
    sreq_nxt = sreq_r;
    preq_nxt = preq_r;
    irqen_nxt = irqen_r;
    ackchk_nxt = ackchk_r;
    ackbr_nxt = ackbr_r;
    ackbt_nxt = ackbt_r;
    busy_nxt = busy_r;
    bitc_nxt = bitc_r;
    ld_nxt = ld_r;
    first_nxt = first_r;
    adr_nxt = adr_r;
    tclr = 1'b0;
    byte_in = {sh_r[6:0], sda_f};
    mx = mst_r & (st_r == ST_XFER);
    halt = ackchk_r & fl_r.no_ack_flag;
    rxing = ~txdir_r | (first_r & ~mst_r);
    // Bit boundary where the next byte is fetched or stalled
    lp = busy_r & (bitc_r == 4'h0) & ~ld_r & ~scl_f & (mx | adr_r);
    hold = 1'b0;

    // Register writes
    if (WR_I) begin
      case (ADDR_I)
        OFS_STATUS: begin
          fl_clr = ~WDATA_I & seen_r;
          seen_nxt = '0;
        end
        OFS_OWN: own_nxt = WDATA_I[7:1];
        OFS_TX: begin
          tx_nxt = WDATA_I;
          fl_clr[B_TXE] = 1'b1;
          fl_clr[B_TRANSMIT_END_FLAG] = 1'b1;
        end
        OFS_CFG: begin
          duty_nxt = WDATA_I[CFG_DUTY];
          nf2_nxt = WDATA_I[CFG_NF2];
        end
        OFS_CTRL: begin
          mst_nxt = WDATA_I[CTL_MST];
          txdir_nxt = WDATA_I[CTL_DIR];
          if (WDATA_I[CTL_DIR] && !txdir_r) begin
            fl_set[B_TXE] = 1'b1;
          end
          sreq_nxt = sreq_r | WDATA_I[CTL_START];
          preq_nxt = preq_r | WDATA_I[CTL_STOP];
        end
        OFS_ACKC: begin
          irqen_nxt = WDATA_I[ACK_IRQEN];
          ackchk_nxt = WDATA_I[ACK_CHK];
          ackbt_nxt = WDATA_I[ACK_ACKBT];
        end
        default: ;  // Receive holding and unmapped: no effect
      endcase
    end

    // Register reads; data stand one cycle later
    if (RD_I) begin
      case (ADDR_I)
        OFS_STATUS: begin
          rdata_nxt = fl_r;
          seen_nxt = fl_r;
        end
        OFS_OWN: rdata_nxt = {own_r, 1'b0};
        OFS_TX: rdata_nxt = tx_r;
        OFS_RX: begin
          rdata_nxt = rx_r;
          fl_clr[B_RXF] = 1'b1;
        end
        OFS_CFG: rdata_nxt = {6'h00, duty_r, nf2_r};
        OFS_CTRL: rdata_nxt = {1'b0, mst_r, txdir_r, 1'b0, busy_r, 1'b0,
                               sreq_r, preq_r};
        OFS_ACKC: rdata_nxt = {3'h0, irqen_r, 1'b0, ackchk_r, ackbr_r,
                               ackbt_r};
        default: rdata_nxt = RST_BYTE;
      endcase
    end

    // Fetch point: stop, repeated start, load or stall
    if (lp) begin
      if (mx && preq_r) begin
        st_nxt = ST_PA;
        preq_nxt = 1'b0;
        tclr = 1'b1;
      end else if (mx && sreq_r) begin
        st_nxt = ST_RS;
        tclr = 1'b1;
      end else if (halt) begin
        hold = 1'b1;
      end else if (txdir_r) begin
        if (!fl_r.transmit_empty_flag) begin
          sh_nxt = tx_r;
          fl_set[B_TXE] = 1'b1;
          ld_nxt = 1'b1;
        end else begin
          hold = 1'b1;
        end
      end else if (!fl_r.receive_full_flag) begin
        ld_nxt = 1'b1;
      end else begin
        hold = 1'b1;
      end
    end

    // Clock rise: sample data, address match, acknowledge
    if (ev.rise && busy_r && ld_r) begin
      if (bitc_r != ACK_BIT) begin
        sh_nxt = byte_in;
        if (mx && txdir_r && !sdal_r && !sda_f) begin
          fl_set[B_AL] = 1'b1;
          mst_nxt = 1'b0;
          st_nxt = ST_IDLE;
        end
        if (bitc_r == 4'h7 && first_r && !mst_r) begin
          if (byte_in[7:1] == own_r ||
              (byte_in[7:1] == GC_ADDR && !byte_in[0])) begin
            adr_nxt = 1'b1;
            fl_set[B_ADR] = 1'b1;
            fl_set[B_GC] = (byte_in[7:1] == GC_ADDR);
            if (byte_in[0]) begin
              txdir_nxt = 1'b1;
              fl_set[B_TXE] = 1'b1;
            end
          end
        end
      end else if (!rxing) begin
        ackbr_nxt = sda_f;
        fl_set[B_NACK] = sda_f & ackchk_r;
        fl_set[B_TRANSMIT_END_FLAG] = fl_r.transmit_empty_flag;
      end else if (mst_r || adr_r) begin
        rx_nxt = sh_r;
        fl_set[B_RXF] = 1'b1;
      end
    end

    // Clock fall: step to the next bit
    if (ev.fall && busy_r && ld_r) begin
      if (bitc_r == ACK_BIT) begin
        bitc_nxt = 4'h0;
        ld_nxt = 1'b0;
        first_nxt = 1'b0;
      end else begin
        bitc_nxt = bitc_r + 4'h1;
      end
    end

    // Master start and stop sequencing
    case (st_r)
      ST_IDLE: begin
        if (mst_r && sreq_r && !busy_r) begin
          st_nxt = ST_SB;
          tclr = 1'b1;
        end
      end
      ST_RS: if (ttick) st_nxt = ST_SB;
      ST_SB: if (ttick) st_nxt = ST_SC;
      ST_SC: begin
        if (ttick) begin
          st_nxt = ST_XFER;
          tclr = 1'b1;
          sreq_nxt = 1'b0;
          fl_set[B_TXE] = txdir_r;
        end
      end
      ST_XFER: if (!mst_r) st_nxt = ST_IDLE;
      ST_PA: if (ttick) st_nxt = ST_PB;
      ST_PB: if (ttick) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase

    // Bus conditions
    if (ev.start) begin
      busy_nxt = 1'b1;
      bitc_nxt = 4'h0;
      first_nxt = 1'b1;
      adr_nxt = 1'b0;
      ld_nxt = ~mst_r;  // Slave takes the address frame as received
      if (mst_r && st_r != ST_IDLE && !sdal_r) begin
        fl_set[B_AL] = 1'b1;
        mst_nxt = 1'b0;
        st_nxt = ST_IDLE;
      end
    end
    if (ev.stop) begin
      fl_set[B_STOP] = mst_r | adr_r;
      busy_nxt = 1'b0;
      adr_nxt = 1'b0;
      ld_nxt = 1'b0;
      bitc_nxt = 4'h0;
    end

    // Flag update; a set in the same cycle wins over a clear
    fl_nxt = isdf_flags_type'((fl_r & ~fl_clr) | fl_set);

    // Pin drive; outside start and stop sequencing, data changes only while the clock is low
    case (st_r)
      ST_RS: begin
        sdal_nxt = 1'b0;
        scll_nxt = 1'b1;
      end
      ST_SB: begin
        sdal_nxt = 1'b0;
        scll_nxt = 1'b0;
      end
      ST_SC: begin
        sdal_nxt = 1'b1;
        scll_nxt = 1'b0;
      end
      ST_PA: begin
        sdal_nxt = 1'b1;
        scll_nxt = 1'b1;
      end
      ST_PB: begin
        sdal_nxt = ~ttick;
        scll_nxt = 1'b0;
      end
      default: begin
        sdal_nxt = sdal_r;
        if (!scl_f) begin
          if (!ld_r || !(mx || adr_r)) begin
            sdal_nxt = 1'b0;
          end else if (bitc_r == ACK_BIT) begin
            sdal_nxt = rxing & ~ackbt_r;
          end else begin
            sdal_nxt = txdir_r & (~first_r | mst_r) ? ~sh_r[7] : 1'b0;
          end
        end
        scll_nxt = (mx & tlow) | (adr_r & hold);
      end
    endcase
  end

  // Registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= ST_IDLE;
      fl_r <= '0;
      seen_r <= '0;
      own_r <= '0;
      tx_r <= RST_BYTE;
      rx_r <= RST_BYTE;
      sh_r <= RST_BYTE;
      rdata_r <= RST_BYTE;
      duty_r <= 1'b0;
      nf2_r <= 1'b0;
      mst_r <= 1'b0;
      txdir_r <= 1'b0;
      sreq_r <= 1'b0;
      preq_r <= 1'b0;
      irqen_r <= 1'b0;
      ackchk_r <= 1'b0;
      ackbr_r <= 1'b0;
      ackbt_r <= 1'b0;
      busy_r <= 1'b0;
      bitc_r <= 4'h0;
      ld_r <= 1'b0;
      first_r <= 1'b0;
      adr_r <= 1'b0;
      sdal_r <= 1'b0;
      scll_r <= 1'b0;
      pscl_r <= 1'b1;
      psda_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      fl_r <= fl_nxt;
      seen_r <= seen_nxt;
      own_r <= own_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      sh_r <= sh_nxt;
      rdata_r <= rdata_nxt;
      duty_r <= duty_nxt;
      nf2_r <= nf2_nxt;
      mst_r <= mst_nxt;
      txdir_r <= txdir_nxt;
      sreq_r <= sreq_nxt;
      preq_r <= preq_nxt;
      irqen_r <= irqen_nxt;
      ackchk_r <= ackchk_nxt;
      ackbr_r <= ackbr_nxt;
      ackbt_r <= ackbt_nxt;
      busy_r <= busy_nxt;
      bitc_r <= bitc_nxt;
      ld_r <= ld_nxt;
      first_r <= first_nxt;
      adr_r <= adr_nxt;
      sdal_r <= sdal_nxt;
      scll_r <= scll_nxt;
      pscl_r <= scl_f;
      psda_r <= sda_f;
    end
  end

  // Outputs; open-drain pins only ever pull low
  assign RDATA_O = rdata_r;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N_O = ~scll_r;
  assign SDA_OE_N_O = ~sdal_r;
  assign NAK_IRQ_O = irqen_r & (fl_r.no_ack_flag |
                                fl_r.arbitration_lost_overrun_flag);
endmodule // isdf_top

// file: isdf_pkg.sv
package isdf_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_STATUS = 3'h0;  // Bus status flags
  localparam logic [2:0] OFS_OWN    = 3'h1;  // Own slave address
  localparam logic [2:0] OFS_TX     = 3'h2;  // Transmit holding
  localparam logic [2:0] OFS_RX     = 3'h3;  // Receive holding
  localparam logic [2:0] OFS_CFG    = 3'h4;  // Filter and duty config
  localparam logic [2:0] OFS_CTRL   = 3'h5;  // Mode and condition control
  localparam logic [2:0] OFS_ACKC   = 3'h6;  // Acknowledge control
  // Status flag positions
  localparam int B_TXE  = 7;
  localparam int B_TRANSMIT_END_FLAG = 6;
  localparam int B_RXF  = 5;
  localparam int B_NACK = 4;
  localparam int B_STOP = 3;
  localparam int B_AL   = 2;
  localparam int B_ADR  = 1;
  localparam int B_GC   = 0;
  // Config, control and acknowledge field positions
  localparam int CFG_DUTY  = 1;
  localparam int CFG_NF2   = 0;
  localparam int CTL_MST   = 6;
  localparam int CTL_DIR   = 5;
  localparam int CTL_BUSY  = 3;
  localparam int CTL_START = 1;
  localparam int CTL_STOP  = 0;
  localparam int ACK_IRQEN = 4;
  localparam int ACK_CHK   = 2;
  localparam int ACK_ACKBR = 1;
  localparam int ACK_ACKBT = 0;
  // Reset values and fixed codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] GC_ADDR  = 7'h00;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned SCL_PERIOD_NS  = 10000;
  localparam int unsigned SCL_PERIOD_CYC = SCL_PERIOD_NS / CLK_PERIOD_NS;
  // Status flags, bit 7 first
  typedef struct packed {
    logic transmit_empty_flag;
    logic transmit_end_flag;
    logic receive_full_flag;
    logic no_ack_flag;
    logic stop_detected_flag;
    logic arbitration_lost_overrun_flag;
    logic address_recognized_flag;
    logic general_call_flag;
  } isdf_flags_type;
  // Conditions seen on the filtered bus lines
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } isdf_events_type;
endpackage

// file: isdf_filter.sv
`timescale 1ns/100ps
module isdf_filter
  import isdf_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,   // Raw bus line
  input  wire logic nf2_i,   // Wide filter range
  output logic      level_o  // Filtered level
);
  logic       meta_r, meta_nxt;  // First synchroniser stage
  logic       sync_r, sync_nxt;  // Second synchroniser stage
  logic [1:0] lat_r, lat_nxt;    // Cascaded sample latches
  logic       lvl_r, lvl_nxt;    // Held filtered value

  // Next values: pass a level only when the samples agree
  always_comb begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
    lat_nxt  = {lat_r[0], sync_r};
    lvl_nxt  = lvl_r;
    if (nf2_i) begin
      if ((sync_r == lat_r[0]) && (lat_r[0] == lat_r[1])) begin
        lvl_nxt = sync_r;
      end
    end else if (sync_r == lat_r[0]) begin
      lvl_nxt = sync_r;
    end
  end

  // Registers; idle bus is high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      lat_r  <= 2'b11;
      lvl_r  <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      lat_r  <= lat_nxt;
      lvl_r  <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;
endmodule // isdf_filter

// file: isdf_scl_timer.sv
`timescale 1ns/100ps
module isdf_scl_timer
  import isdf_pkg::*;
#(
  parameter int unsigned PERIOD = SCL_PERIOD_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic clr_i,    // Restart at the low phase
  input  wire logic pause_i,  // Hold the count
  input  wire logic duty_i,   // Short high phase
  input  wire logic scl_i,    // Filtered clock line
  output logic      low_o,    // Low phase of the clock
  output logic      tick_o    // Last cycle of a phase
);
  localparam int unsigned CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] FULL    = CW'(PERIOD);
  localparam logic [CW-1:0] HI_EVEN = CW'(PERIOD / 2);
  localparam logic [CW-1:0] HI_LONG = CW'((PERIOD * 2) / 5);
  logic [CW-1:0] cnt_r, cnt_nxt;   // Cycles in this phase
  logic          high_r, high_nxt; // High phase
  logic [CW-1:0] len;              // Length of this phase
  logic          stall;            // Count frozen

  // Phase lengths follow the duty select; high waits on the line
  always_comb begin
    if (high_r) begin
      len = duty_i ? HI_LONG : HI_EVEN;
    end else begin
      len = duty_i ? FULL - HI_LONG : FULL - HI_EVEN;
    end
    stall    = pause_i | (high_r & ~scl_i);
    tick_o   = ~stall & (cnt_r == len - CW'(1));
    cnt_nxt  = cnt_r;
    high_nxt = high_r;
    if (clr_i) begin
      cnt_nxt  = '0;
      high_nxt = 1'b0;
    end else if (tick_o) begin
      cnt_nxt  = '0;
      high_nxt = ~high_r;
    end else if (!stall) begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      high_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      high_r <= high_nxt;
    end
  end

  assign low_o = ~high_r;
endmodule // isdf_scl_timer

// file: isdf_slave_model.sv
`timescale 1ns/100ps
// Receiving slave on the far side of the two-wire bus
module isdf_slave_model (
  input  wire logic       scl_i,       // Wired clock line
  input  wire logic       sda_i,       // Wired data line
  input  wire logic       nack_i,      // Refuse the next bytes
  output logic            sda_oe_n_o,  // Low while pulling data low
  output logic      [7:0] byte_o,      // Last byte taken
  output logic      [7:0] count_o      // Bytes taken so far
);
  int         cnt = 0;      // Bit position in the frame
  logic [7:0] sh  = 8'h00;  // Shift register
  initial begin
    sda_oe_n_o = 1'b1;
    byte_o     = 8'h00;
    count_o    = 8'h00;
  end
  // Data falling with clock high opens a frame
  always @(negedge sda_i) begin
    if (scl_i) cnt = 0;
  end
  // Data rising with clock high ends the transfer
  always @(posedge sda_i) begin
    if (scl_i) cnt = 0;
  end
  // Sample on the clock rise, most significant bit first
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    cnt = cnt + 1;
  end
  // Acknowledge after eight bits, release after the ninth
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      sda_oe_n_o <= nack_i;
      byte_o     <= sh;
      count_o    <= count_o + 8'h01;
    end else if (cnt == 9) begin
      sda_oe_n_o <= 1'b1;
      cnt = 0;
    end
  end
endmodule // isdf_slave_model

// file: isdf_asserts.sv
`timescale 1ns/100ps
// Checks on the register port and the bus pins of the top module
module isdf_asserts
  import isdf_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       SCL_I,
  input wire logic       SCL_OE_N_O,
  input wire logic       SDA_OE_N_O,
  input wire logic       NAK_IRQ_O
);
  logic [7:0] wd_r;    // Last written data
  logic [7:0] wd_nxt;  // Next value of it
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Keep the last write data for read-back checks
  always_comb begin
    wd_nxt = WR_I ? WDATA_I : wd_r;
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) wd_r <= 8'h00;
    else wd_r <= wd_nxt;
  end
  AST_CFG_ZERO: assert property (
    RD_I && ADDR_I == OFS_CFG |=> RDATA_O[7:2] == 6'h00)
    else $error("Config upper bits not zero");
  AST_OWN_BIT0: assert property (
    RD_I && ADDR_I == OFS_OWN |=> !RDATA_O[0])
    else $error("Own address bit 0 not zero");
  AST_OWN_BACK: assert property (
    WR_I && ADDR_I == OFS_OWN ##1 RD_I && ADDR_I == OFS_OWN
    |=> RDATA_O[7:1] == wd_r[7:1])
    else $error("Own address bits lost");
  AST_TRANSMIT_END_FLAG_CLR: assert property (
    WR_I && ADDR_I == OFS_TX ##1 RD_I && ADDR_I == OFS_STATUS
    |=> !RDATA_O[B_TRANSMIT_END_FLAG])
    else $error("Transmit end kept after holding write");
  AST_KEEP: assert property (
    RD_I && ADDR_I == OFS_STATUS ##1
    WR_I && ADDR_I == OFS_STATUS && WDATA_I == 8'hff ##1
    RD_I && ADDR_I == OFS_STATUS
    |=> (RDATA_O & $past(RDATA_O, 2)) == $past(RDATA_O, 2))
    else $error("Flag lost on write of ones");
  AST_CLEAR: assert property (
    RD_I && ADDR_I == OFS_STATUS ##1
    WR_I && ADDR_I == OFS_STATUS && WDATA_I == 8'h00 ##1
    RD_I && ADDR_I == OFS_STATUS
    |=> (RDATA_O & $past(RDATA_O, 2) & 8'h1c) == 8'h00)
    else $error("Flag kept after read then zero");
  AST_START: assert property (
    $fell(SDA_OE_N_O) && SCL_I |-> SCL_OE_N_O [*2])
    else $error("Clock not high around start");
  AST_STOP: assert property (
    $rose(SDA_OE_N_O) && SCL_I |-> SCL_OE_N_O [*2])
    else $error("Clock not high around stop");
  AST_IRQ_OFF: assert property (
    WR_I && ADDR_I == OFS_ACKC && !WDATA_I[ACK_IRQEN]
    |-> ##[1:2] !NAK_IRQ_O)
    else $error("No-ack request kept without enable");
  // Main scenarios reached
  cover property ($fell(SDA_OE_N_O) && SCL_I);
  cover property ($rose(SDA_OE_N_O) && SCL_I);
  cover property ($rose(NAK_IRQ_O));
endmodule // isdf_asserts
bind isdf_top isdf_asserts u_chk (.CLK_I, .RST_N_I, .ADDR_I, .WDATA_I,
  .WR_I, .RD_I, .RDATA_O, .SCL_I, .SCL_OE_N_O, .SDA_OE_N_O, .NAK_IRQ_O);

// file: testbench.sv
`timescale 1ns/100ps
// Register port checks and a master transmit to the slave model
module testbench;
  import isdf_pkg::*;
  logic       clk   = 1'b0;  // 20 MHz clock
  logic       rst_n = 1'b0;  // Reset, active low
  logic [2:0] addr  = 3'h0;  // Register index
  logic [7:0] wdata = 8'h00; // Write data
  logic       wr    = 1'b0;  // Write strobe
  logic       rd    = 1'b0;  // Read strobe
  logic       nack  = 1'b0;  // Slave model refuses bytes
  logic [7:0] rdata;         // Read data
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, irq;
  logic       m_oe_n;        // Slave model data enable
  logic [7:0] m_byte;        // Last byte the model took
  logic [7:0] m_count;       // Bytes the model took
  logic [7:0] v;             // Read-back value
  int         err_count   = 0;
  int         checks_done = 0;
  // Open-drain lines with pull-ups
  wire        scl_w = scl_oe_n ? 1'b1 : scl_o;
  wire        sda_w = (sda_oe_n ? 1'b1 : sda_o) & m_oe_n;
  initial forever #25 clk = ~clk;
  isdf_top #(.SCL_CYC(20)) uut (
    .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SCL_I(scl_w),
    .SCL_O(scl_o), .SCL_OE_N_O(scl_oe_n), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .NAK_IRQ_O(irq)
  );
  isdf_slave_model model (
    .scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
    .sda_oe_n_o(m_oe_n), .byte_o(m_byte), .count_o(m_count)
  );
  // Verdict and end of run
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle, launched right after a rising edge
  task automatic bus(input logic w, input logic r, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= d;
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask
  // Read; data is taken in the cycle after the strobe
  task automatic rdr(input logic [2:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    #1 d = rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                     input logic [7:0] m);
    rdr(a, v);
    chk(v & m, e);
  endtask
  // Poll status until the masked flags are set, bounded
  task automatic wait_bit(input logic [7:0] m);
    for (int i = 0; i < 600; i++) begin
      rdr(OFS_STATUS, v);
      if ((v & m) === m) return;
    end
    chk(v & m, m);
    give_verdict();
  endtask
  // Reset values, reserved bits, read-only and unmapped places
  task automatic t_regs();
    rdc(OFS_STATUS, 8'h00, 8'hff);
    rdc(OFS_CFG, 8'h00, 8'hff);
    wrr(OFS_CFG, 8'hff);
    rdc(OFS_CFG, 8'h03, 8'hff);
    wrr(OFS_CFG, 8'h00);
    bus(1'b1, 1'b0, OFS_OWN, 8'hff);
    rdc(OFS_OWN, 8'hfe, 8'hff);
    wrr(OFS_RX, 8'h5a);
    rdc(OFS_RX, 8'h00, 8'hff);
    rdc(3'h7, 8'h00, 8'hff);
  endtask
  // Address byte acked, data byte refused, flag clearing, stop
  task automatic t_master();
    wrr(OFS_ACKC, 8'h14);           // Ack check and request enable
    wrr(OFS_CTRL, 8'h60);           // Master, transmit direction
    rdc(OFS_STATUS, 8'h80, 8'h80);
    wrr(OFS_TX, 8'h55);             // Idle bus: nothing is loaded
    rdc(OFS_STATUS, 8'h00, 8'h80);
    wrr(OFS_CTRL, 8'h62);           // Start request
    wait_bit(8'h80);
    wrr(OFS_TX, 8'ha4);
    wait_bit(8'h40);
    chk(m_byte, 8'ha4);
    chk(m_count, 8'h01);
    rdc(OFS_ACKC, 8'h00, 8'h02);
    nack <= 1'b1;
    bus(1'b1, 1'b0, OFS_TX, 8'h3c);
    rdc(OFS_STATUS, 8'h00, 8'h40);
    wait_bit(8'h10);
    chk(m_byte, 8'h3c);
    chk({7'h00, irq}, 8'h01);
    bus(1'b0, 1'b1, OFS_STATUS, 8'h00);
    bus(1'b1, 1'b0, OFS_STATUS, 8'hff);
    rdc(OFS_STATUS, 8'h10, 8'h10);
    bus(1'b0, 1'b1, OFS_STATUS, 8'h00);
    bus(1'b1, 1'b0, OFS_STATUS, 8'h00);
    rdc(OFS_STATUS, 8'h00, 8'h10);
    chk({7'h00, irq}, 8'h00);
    nack <= 1'b0;
    wrr(OFS_CTRL, 8'h61);           // Stop request
    wait_bit(8'h08);
    chk({6'h00, scl_w, sda_w}, 8'h03);
    wrr(OFS_ACKC, 8'h00);
  endtask
  // Reset for three cycles, let the filters see idle lines
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_regs();
    t_master();
    give_verdict();
  end
endmodule // testbench
